// ===== inc/csia_pkg.sv
package csia_pkg;
    // ------------------------------------------------------------
    // Stack geometry and fault reset
    // ------------------------------------------------------------
    localparam int          STACK_WIDTH   = 15;
    localparam int          STACK_DEPTH   = 16;
    localparam logic [14:0] RESET_VECTOR  = 15'h0000;

    // ------------------------------------------------------------
    // Pointers and memory map
    // ------------------------------------------------------------
    localparam int          PTR_WIDTH     = 16;
    localparam int          PTR_COUNT     = 2;
    localparam logic [15:0] LINEAR_BASE   = 16'h2000;
    localparam logic [15:0] LINEAR_LAST   = 16'h29af;
    localparam logic [15:0] PROG_BASE     = 16'h8000;
    localparam logic [11:0] BANK_GPR_SIZE = 12'h050;
    localparam logic [6:0]  BANK_GPR_BASE = 7'h20;
    localparam logic [15:0] PTR_RESET     = 16'h0000;

    // ------------------------------------------------------------
    // Instruction indices (pre-decoded by fetch)
    // ------------------------------------------------------------
    localparam int          NUM_INSTR     = 48;
    localparam logic [5:0]  IDX_CALL      = 6'h00;
    localparam logic [5:0]  IDX_CALLW     = 6'h01;
    localparam logic [5:0]  IDX_RETURN    = 6'h02;
    localparam logic [5:0]  IDX_RETLW     = 6'h03;
    localparam logic [5:0]  IDX_RETFIE    = 6'h04;
    localparam logic [5:0]  IDX_ADDFSR    = 6'h05;
    localparam logic [5:0]  IDX_MOVIW     = 6'h06;
    localparam logic [5:0]  IDX_MOVWI     = 6'h07;
    localparam logic [5:0]  IDX_LDPTRL    = 6'h08;
    localparam logic [5:0]  IDX_LDPTRH    = 6'h09;

    // ------------------------------------------------------------
    // Access sequencer states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE      = 2'b01,
        ST_PROG_WAIT = 2'b10
    } csia_state_e;
endpackage : csia_pkg

// ===== logic/csia_core.sv
`timescale 1ns/10ps
// Functional notes
// (R01) Return-address stack of sixteen entries, fifteen bits each.
// (R02) Push when full sets overflow flag; pop when empty sets underflow flag.
// (R03) With fault reset enabled, overflow or underflow triggers a software-type reset.
// (R04) Two sixteen-bit pointers reach all data memory and program memory.
// (R05) Indirect access to program memory takes one extra instruction cycle.
// (R06) General-purpose memory is also reachable as one linear address space.
// (R07) Interrupt entry saves core context to shadows; return restores it.
// (R08) Forty-eight instructions are accepted; this block sequences its own.
// (R09) Fault reset loads program counter with zero; the causing overflow or underflow flag is set.
module csia_core (
    input  wire logic        clk_sys,              // Instruction clock
    input  wire logic        reset_n,              // Async reset, active low
    input  wire logic        instrValid,           // Instruction issued
    input  wire logic [5:0]  instrIdx,             // Pre-decoded instruction index
    input  wire logic        instrSel,             // Pointer select
    input  wire logic [7:0]  instrOperand,         // Offset or load byte
    input  wire logic [14:0] retAddr,              // Address to push
    input  wire logic        intEntry,             // Interrupt entry
    input  wire logic [7:0]  ctxWreg,              // Working register
    input  wire logic [4:0]  ctxStatus,            // Status bits
    input  wire logic [5:0]  ctxBank,              // Bank select
    input  wire logic [6:0]  ctxPcHigh,            // PC high latch
    input  wire logic        stackFaultResetEnable,// Fault reset option
    input  wire logic        clrOverflow,          // Clear overflow flag
    input  wire logic        clrUnderflow,         // Clear underflow flag
    output logic             busy_r,               // Stall fetch
    output logic             illegal_r,            // Index out of range
    output logic [14:0]      popAddr_r,            // Return address popped
    output logic             popValid_r,           // Pop result valid
    output logic [4:0]       stackCount_r,         // Entries held
    output logic             stackOverflowFlag_r,  // Sticky overflow
    output logic             stackUnderflowFlag_r, // Sticky underflow
    output logic             faultReset_r,         // Software-type reset pulse
    output logic [14:0]      pcLoad_r,             // PC value on fault reset
    output logic [15:0]      ptr0_r,               // Pointer 0
    output logic [15:0]      ptr1_r,               // Pointer 1
    output logic             accValid_r,           // Memory access strobe
    output logic             accWrite_r,           // Access is a write
    output logic             accProg_r,            // Access targets program memory
    output logic [11:0]      dataAddr_r,           // Banked data address
    output logic [14:0]      progAddr_r,           // Program memory address
    output logic             restoreValid_r,       // Context restored
    output logic [7:0]       rstWreg_r,            // Restored working register
    output logic [4:0]       rstStatus_r,          // Restored status
    output logic [5:0]       rstBank_r,            // Restored bank select
    output logic [6:0]       rstPcHigh_r           // Restored PC high latch
);
    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    logic [14:0] stackMem [csia_pkg::STACK_DEPTH];
    logic [7:0]  shWreg_r;
    logic [4:0]  shStatus_r;
    logic [5:0]  shBank_r;
    logic [6:0]  shPcHigh_r;
    logic [15:0] shPtr0_r;
    logic [15:0] shPtr1_r;
    csia_pkg::csia_state_e state_r;
    logic        accWrite_nxt;
    logic        accProgLatch_r;

    logic        go;
    logic        legal;
    logic        doPush;
    logic        doPop;
    logic        doRetfie;
    logic        doAccess;
    logic        full;
    logic        empty;
    logic        fault;
    logic [15:0] selPtr;
    logic [15:0] effAddr;
    logic [15:0] offsetExt;

    assign go        = instrValid && (state_r == csia_pkg::ST_IDLE) && !faultReset_r;
    assign legal     = instrIdx < 6'(csia_pkg::NUM_INSTR);                                   // [R08]
    assign doRetfie  = go && legal && instrIdx == csia_pkg::IDX_RETFIE;
    assign doPush    = (go && legal && (instrIdx == csia_pkg::IDX_CALL || instrIdx == csia_pkg::IDX_CALLW))
                       || intEntry;
    assign doPop     = go && legal && (instrIdx == csia_pkg::IDX_RETURN || instrIdx == csia_pkg::IDX_RETLW
                       || doRetfie);
    assign doAccess  = go && legal && (instrIdx == csia_pkg::IDX_MOVIW || instrIdx == csia_pkg::IDX_MOVWI);
    assign full      = stackCount_r == 5'(csia_pkg::STACK_DEPTH);
    assign empty     = stackCount_r == 5'h00;
    assign fault     = stackFaultResetEnable && ((doPush && full) || (doPop && empty));      // [R03]
    assign selPtr    = instrSel ? ptr1_r : ptr0_r;
    assign offsetExt = {{8{instrOperand[7]}}, instrOperand};
    assign effAddr   = selPtr + offsetExt;
    assign accWrite_nxt = instrIdx == csia_pkg::IDX_MOVWI;

    // Map a pointer value onto banked data space
    function automatic logic [11:0] map_data(input logic [15:0] addr);
        logic [11:0] lin;
        logic [11:0] bank;
        logic [11:0] off;
        lin  = 12'h000;
        bank = 12'h000;
        off  = 12'h000;
        if (addr >= csia_pkg::LINEAR_BASE && addr <= csia_pkg::LINEAR_LAST) begin
            lin  = 12'(addr - csia_pkg::LINEAR_BASE);                                       // [R06]
            bank = lin / csia_pkg::BANK_GPR_SIZE;
            off  = lin % csia_pkg::BANK_GPR_SIZE;
            map_data = {bank[4:0], csia_pkg::BANK_GPR_BASE + off[6:0]};
        end else begin
            map_data = addr[11:0];
        end
    endfunction : map_data

    // ------------------------------------------------------------
    // Return-address stack
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (doPush && !full && !faultReset_r) begin
            stackMem[stackCount_r[3:0]] <= retAddr;                                           // [R01]
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            stackCount_r <= 5'h00;
            popAddr_r    <= 15'h0000;
            popValid_r   <= 1'b0;
        end else begin
            popValid_r <= 1'b0;
            if (faultReset_r) begin
                stackCount_r <= 5'h00;
            end else if (doPush && doPop) begin
                popAddr_r  <= retAddr;
                popValid_r <= 1'b1;
            end else if (doPush && !full) begin
                stackCount_r <= stackCount_r + 5'h01;                                         // [R01]
            end else if (doPop && !empty) begin
                stackCount_r <= stackCount_r - 5'h01;
                popAddr_r    <= stackMem[4'(stackCount_r - 5'h01)];
                popValid_r   <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Fault flags and fault reset
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            stackOverflowFlag_r  <= 1'b0;
            stackUnderflowFlag_r <= 1'b0;
        end else begin
            if (doPush && full && !doPop) begin
                stackOverflowFlag_r <= 1'b1;                                                  // [R02] [R09]
            end else if (clrOverflow) begin
                stackOverflowFlag_r <= 1'b0;
            end
            if (doPop && empty && !doPush) begin
                stackUnderflowFlag_r <= 1'b1;                                                 // [R02] [R09]
            end else if (clrUnderflow) begin
                stackUnderflowFlag_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            faultReset_r <= 1'b0;
            pcLoad_r     <= csia_pkg::RESET_VECTOR;
            illegal_r    <= 1'b0;
        end else begin
            faultReset_r <= fault && !(doPush && doPop);                                      // [R03]
            pcLoad_r     <= csia_pkg::RESET_VECTOR;                                           // [R09]
            illegal_r    <= go && !legal;                                                     // [R08]
        end
    end

    // ------------------------------------------------------------
    // Pointers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ptr0_r <= csia_pkg::PTR_RESET;
            ptr1_r <= csia_pkg::PTR_RESET;
        end else if (faultReset_r) begin
            ptr0_r <= csia_pkg::PTR_RESET;
            ptr1_r <= csia_pkg::PTR_RESET;
        end else if (doRetfie) begin
            ptr0_r <= shPtr0_r;                                                               // [R07]
            ptr1_r <= shPtr1_r;
        end else if (go && legal) begin
            case (instrIdx)
                csia_pkg::IDX_ADDFSR: begin
                    if (instrSel) ptr1_r <= effAddr;                                          // [R04]
                    else ptr0_r <= effAddr;
                end
                csia_pkg::IDX_LDPTRL: begin
                    if (instrSel) ptr1_r[7:0] <= instrOperand;
                    else ptr0_r[7:0] <= instrOperand;
                end
                csia_pkg::IDX_LDPTRH: begin
                    if (instrSel) ptr1_r[15:8] <= instrOperand;
                    else ptr0_r[15:8] <= instrOperand;
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Indirect access sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_r        <= csia_pkg::ST_IDLE;
            busy_r         <= 1'b0;
            accValid_r     <= 1'b0;
            accWrite_r     <= 1'b0;
            accProg_r      <= 1'b0;
            accProgLatch_r <= 1'b0;
            dataAddr_r     <= 12'h000;
            progAddr_r     <= 15'h0000;
        end else begin
            accValid_r <= 1'b0;
            case (state_r)
                csia_pkg::ST_IDLE: begin
                    if (doAccess) begin
                        dataAddr_r <= map_data(effAddr);                                      // [R04] [R06]
                        progAddr_r <= effAddr[14:0];
                        accWrite_r <= accWrite_nxt;
                        if (effAddr >= csia_pkg::PROG_BASE) begin
                            state_r        <= csia_pkg::ST_PROG_WAIT;                         // [R05]
                            busy_r         <= 1'b1;
                            accProgLatch_r <= 1'b1;
                        end else begin
                            accValid_r <= 1'b1;
                            accProg_r  <= 1'b0;
                        end
                    end
                end
                csia_pkg::ST_PROG_WAIT: begin
                    state_r        <= csia_pkg::ST_IDLE;                                      // [R05]
                    busy_r         <= 1'b0;
                    accValid_r     <= 1'b1;
                    accProg_r      <= accProgLatch_r;
                    accProgLatch_r <= 1'b0;
                end
                default: begin
                    state_r <= csia_pkg::ST_IDLE;
                    busy_r  <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Shadow context
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            shWreg_r       <= 8'h00;
            shStatus_r     <= 5'h00;
            shBank_r       <= 6'h00;
            shPcHigh_r     <= 7'h00;
            shPtr0_r       <= csia_pkg::PTR_RESET;
            shPtr1_r       <= csia_pkg::PTR_RESET;
            restoreValid_r <= 1'b0;
            rstWreg_r      <= 8'h00;
            rstStatus_r    <= 5'h00;
            rstBank_r      <= 6'h00;
            rstPcHigh_r    <= 7'h00;
        end else begin
            restoreValid_r <= 1'b0;
            if (intEntry) begin
                shWreg_r   <= ctxWreg;                                                        // [R07]
                shStatus_r <= ctxStatus;
                shBank_r   <= ctxBank;
                shPcHigh_r <= ctxPcHigh;
                shPtr0_r   <= ptr0_r;
                shPtr1_r   <= ptr1_r;
            end else if (doRetfie) begin
                restoreValid_r <= 1'b1;                                                       // [R07]
                rstWreg_r      <= shWreg_r;
                rstStatus_r    <= shStatus_r;
                rstBank_r      <= shBank_r;
                rstPcHigh_r    <= shPcHigh_r;
            end
        end
    end
endmodule : csia_core

// ===== bench/csia_core_sva.sv
`timescale 1ns/10ps
module csia_core_sva (
    input wire logic        clk_sys,               // Clock
    input wire logic        reset_n,               // Reset
    input wire logic        instrValid,            // Issue
    input wire logic [5:0]  instrIdx,              // Index
    input wire logic        instrSel,              // Pointer select
    input wire logic [7:0]  instrOperand,          // Operand
    input wire logic [14:0] retAddr,               // Push address
    input wire logic        intEntry,              // Interrupt entry
    input wire logic        stackFaultResetEnable, // Fault reset option
    input wire logic        busy_r,                // Stall
    input wire logic        illegal_r,             // Illegal index
    input wire logic [14:0] popAddr_r,             // Popped address
    input wire logic        popValid_r,            // Pop strobe
    input wire logic [4:0]  stackCount_r,          // Depth
    input wire logic        stackOverflowFlag_r,   // Overflow
    input wire logic        stackUnderflowFlag_r,  // Underflow
    input wire logic        faultReset_r,          // Fault reset
    input wire logic [14:0] pcLoad_r,              // PC load
    input wire logic [15:0] ptr0_r,                // Pointer 0
    input wire logic        accValid_r,            // Access strobe
    input wire logic        accProg_r,             // Program access
    input wire logic        restoreValid_r         // Context restored
);
    // ------------------------------------------------------------
    // Accepted instructions
    // ------------------------------------------------------------
    wire logic take = instrValid && !busy_r && !faultReset_r;
    wire logic call = take && instrIdx == csia_pkg::IDX_CALL && !intEntry;
    wire logic ret  = take && instrIdx == csia_pkg::IDX_RETURN && !intEntry;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    depth_max_a: assert property (stackCount_r <= 5'd16)
        else $error("stack count above sixteen");
    push_count_a: assert property (call && stackCount_r < 5'd16
        |=> stackCount_r == $past(stackCount_r) + 5'd1)
        else $error("push did not raise count");
    stack_order_a: assert property (call && stackCount_r < 5'd16 ##1 ret
        |=> popValid_r && popAddr_r == $past(retAddr, 2))
        else $error("pop did not return last push");
    overflow_flag_a: assert property (call && stackCount_r == 5'd16 |=> stackOverflowFlag_r)
        else $error("overflow flag not set");
    underflow_flag_a: assert property (ret && stackCount_r == 5'd0 |=> stackUnderflowFlag_r && !popValid_r)
        else $error("underflow flag not set");
    fault_reset_a: assert property ((call && stackCount_r == 5'd16 || ret && stackCount_r == 5'd0)
        && stackFaultResetEnable |=> faultReset_r ##1 (stackCount_r == 5'd0 && ptr0_r == 16'h0000))
        else $error("fault reset missing");
    reset_vector_a: assert property (faultReset_r |-> pcLoad_r == 15'h0000 && $past(stackFaultResetEnable))
        else $error("fault reset bad vector or not enabled");
    prog_wait_a: assert property ($rose(busy_r) |=> !busy_r && accValid_r && accProg_r)
        else $error("program access not after one extra cycle");
    data_access_a: assert property (take && instrIdx == csia_pkg::IDX_MOVIW && !instrSel && !ptr0_r[15]
        && instrOperand == 8'h00 && !intEntry |=> accValid_r && !accProg_r && !busy_r)
        else $error("data access not immediate");
    ctx_restore_a: assert property (take && instrIdx == csia_pkg::IDX_RETFIE && !intEntry
        && stackCount_r != 5'd0 |=> restoreValid_r && popValid_r)
        else $error("context not restored");
    illegal_idx_a: assert property (take && instrIdx >= 6'd48 |=> illegal_r)
        else $error("illegal index not flagged");
endmodule : csia_core_sva

bind csia_core csia_core_sva csia_core_sva_inst (.clk_sys, .reset_n, .instrValid, .instrIdx, .instrSel,
    .instrOperand, .retAddr, .intEntry, .stackFaultResetEnable, .busy_r, .illegal_r, .popAddr_r, .popValid_r,
    .stackCount_r, .stackOverflowFlag_r, .stackUnderflowFlag_r, .faultReset_r, .pcLoad_r, .ptr0_r, .accValid_r,
    .accProg_r, .restoreValid_r);

// ===== bench/csia_core_tb.sv
`timescale 1ns/10ps
module csia_core_tb;
    logic        clk_sys, reset_n, instrValid, instrSel, intEntry, stackFaultResetEnable, clrOverflow, clrUnderflow;
    logic [5:0]  instrIdx, ctxBank, rstBank_r;
    logic [7:0]  instrOperand, ctxWreg, rstWreg_r;
    logic [4:0]  ctxStatus, rstStatus_r, stackCount_r;
    logic [6:0]  ctxPcHigh, rstPcHigh_r;
    logic [14:0] retAddr, popAddr_r, pcLoad_r, progAddr_r;
    logic [15:0] ptr0_r, ptr1_r;
    logic [11:0] dataAddr_r;
    logic        busy_r, illegal_r, popValid_r, stackOverflowFlag_r, stackUnderflowFlag_r, faultReset_r;
    logic        accValid_r, accWrite_r, accProg_r, restoreValid_r;
    int          n_errors, checks, cyc;

    csia_core csia_core_inst (.clk_sys, .reset_n, .instrValid, .instrIdx, .instrSel, .instrOperand, .retAddr,
        .intEntry, .ctxWreg, .ctxStatus, .ctxBank, .ctxPcHigh, .stackFaultResetEnable, .clrOverflow, .clrUnderflow,
        .busy_r, .illegal_r, .popAddr_r, .popValid_r, .stackCount_r, .stackOverflowFlag_r, .stackUnderflowFlag_r,
        .faultReset_r, .pcLoad_r, .ptr0_r, .ptr1_r, .accValid_r, .accWrite_r, .accProg_r, .dataAddr_r, .progAddr_r,
        .restoreValid_r, .rstWreg_r, .rstStatus_r, .rstBank_r, .rstPcHigh_r);

    // ------------------------------------------------------------
    // Clock, timeout and shared tasks
    // ------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 2000) begin
            n_errors++;
            results();
        end
    end

    task chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task op(input logic [5:0] idx, input logic sel, input logic [7:0] opnd, input logic [14:0] ra);
        instrValid = 1'b1;
        instrIdx = idx;
        instrSel = sel;
        instrOperand = opnd;
        retAddr = ra;
        @(posedge clk_sys);
        #1;
    endtask : op

    task idle(input int n);
        if (n > 0) instrValid = 1'b0;
        repeat (n) begin
            @(posedge clk_sys);
            #1;
        end
    endtask : idle

    task ldptr(input logic sel, input logic [15:0] v);
        op(csia_pkg::IDX_LDPTRL, sel, v[7:0], 15'h0000);
        op(csia_pkg::IDX_LDPTRH, sel, v[15:8], 15'h0000);
    endtask : ldptr

    task clrflags;
        clrOverflow = 1'b1;
        clrUnderflow = 1'b1;
        idle(1);
        clrOverflow = 1'b0;
        clrUnderflow = 1'b0;
        chk({stackOverflowFlag_r, stackUnderflowFlag_r}, 16'h0000, "flags clear");
    endtask : clrflags

    task results;
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : results

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task s_stack;
        for (int i = 0; i < 16; i++) op(csia_pkg::IDX_CALL, 1'b0, 8'h00, 15'h0100 + 15'(i));
        op(csia_pkg::IDX_CALL, 1'b0, 8'h00, 15'h7fff);
        idle(0);
        chk({stackOverflowFlag_r, faultReset_r, stackCount_r}, {9'h0, 2'b10, 5'd16}, "overflow");
        for (int i = 15; i >= 0; i--) begin
            op(csia_pkg::IDX_RETURN, 1'b0, 8'h00, 15'h0000);
            chk({popValid_r, popAddr_r}, {1'b1, 15'h0100 + 15'(i)}, "pop order");
        end
        op(csia_pkg::IDX_RETURN, 1'b0, 8'h00, 15'h0000);
        idle(0);
        chk({popValid_r, stackUnderflowFlag_r, faultReset_r}, 16'h0002, "underflow");
        clrflags();
    endtask : s_stack

    task s_fault;
        ldptr(1'b0, 16'h1234);
        stackFaultResetEnable = 1'b1;
        for (int i = 0; i < 17; i++) op(csia_pkg::IDX_CALL, 1'b0, 8'h00, 15'h0200);
        idle(0);
        chk({faultReset_r, stackOverflowFlag_r, stackUnderflowFlag_r}, 16'h0006, "overflow reset");
        chk(pcLoad_r, 16'h0000, "reset vector");
        idle(1);
        chk({stackCount_r, ptr0_r[10:0]}, 16'h0000, "fault clears");
        op(csia_pkg::IDX_RETURN, 1'b0, 8'h00, 15'h0000);
        idle(0);
        chk({faultReset_r, stackOverflowFlag_r, stackUnderflowFlag_r}, 16'h0007, "underflow reset");
        idle(1);
        stackFaultResetEnable = 1'b0;
        clrflags();
    endtask : s_fault

    task s_ptr;
        static logic [15:0] la [4] = '{16'h2000, 16'h204f, 16'h29af, 16'h00a5};
        static logic [11:0] ba [4] = '{12'h020, 12'h06f, 12'hf6f, 12'h0a5};
        for (int i = 0; i < 4; i++) begin
            ldptr(1'b0, la[i]);
            op(csia_pkg::IDX_MOVIW, 1'b0, 8'h00, 15'h0000);
            idle(0);
            chk({accValid_r, accProg_r, accWrite_r, busy_r, dataAddr_r}, {4'b1000, ba[i]}, "data addr");
        end
        ldptr(1'b0, 16'h2050);
        op(csia_pkg::IDX_MOVIW, 1'b0, 8'hff, 15'h0000);
        idle(0);
        chk(dataAddr_r, 16'h006f, "negative offset");
        ldptr(1'b1, 16'h8007);
        op(csia_pkg::IDX_MOVWI, 1'b1, 8'hfe, 15'h0000);
        idle(0);
        chk({busy_r, accValid_r, progAddr_r[13:0]}, 16'h8005, "extra cycle");
        idle(1);
        chk({busy_r, accValid_r, accProg_r, accWrite_r}, 16'h0007, "program access");
        chk(ptr1_r, 16'h8007, "pointer kept");
        op(csia_pkg::IDX_ADDFSR, 1'b1, 8'hf9, 15'h0000);
        idle(0);
        chk(ptr1_r, 16'h8000, "pointer add");
    endtask : s_ptr

    task s_ctx;
        ldptr(1'b0, 16'h2345);
        op(csia_pkg::IDX_CALL, 1'b0, 8'h00, 15'h1234);
        op(csia_pkg::IDX_RETURN, 1'b0, 8'h00, 15'h0000);
        idle(0);
        chk({popValid_r, popAddr_r}, {1'b1, 15'h1234}, "call return");
        op(csia_pkg::IDX_CALLW, 1'b0, 8'h00, 15'h0555);
        op(csia_pkg::IDX_RETLW, 1'b0, 8'h00, 15'h0000);
        chk({popValid_r, popAddr_r}, {1'b1, 15'h0555}, "callw retlw");
        {ctxWreg, ctxStatus, ctxBank, ctxPcHigh} = {8'ha5, 5'h15, 6'h2a, 7'h4c};
        intEntry = 1'b1;
        retAddr = 15'h4321;
        idle(1);
        intEntry = 1'b0;
        {ctxWreg, ctxStatus, ctxBank, ctxPcHigh} = {8'h5a, 5'h0a, 6'h15, 7'h33};
        op(csia_pkg::IDX_ADDFSR, 1'b0, 8'h01, 15'h0000);
        op(csia_pkg::IDX_RETFIE, 1'b0, 8'h00, 15'h0000);
        idle(0);
        chk({restoreValid_r, popAddr_r}, {1'b1, 15'h4321}, "restore");
        chk({rstWreg_r, rstBank_r, 2'b00}, {8'ha5, 6'h2a, 2'b00}, "shadow a");
        chk({rstStatus_r, rstPcHigh_r}, {4'h0, 5'h15, 7'h4c}, "shadow b");
        chk(ptr0_r, 16'h2345, "pointer restore");
    endtask : s_ctx

    task s_illegal;
        static logic [5:0] ix [3] = '{6'd48, 6'd63, 6'd47};
        for (int i = 0; i < 3; i++) begin
            op(ix[i], 1'b0, 8'h00, 15'h0000);
            idle(0);
            chk(illegal_r, (i < 2) ? 16'h0001 : 16'h0000, "index range");
        end
    endtask : s_illegal

    initial begin
        {reset_n, instrValid, instrSel, intEntry, stackFaultResetEnable, clrOverflow, clrUnderflow} = '0;
        {instrIdx, instrOperand, retAddr, ctxWreg, ctxStatus, ctxBank, ctxPcHigh} = '0;
        repeat (4) @(posedge clk_sys);
        #1 reset_n = 1'b1;
        chk({stackCount_r, busy_r, faultReset_r, ptr0_r[8:0]}, 16'h0000, "after reset");
        s_stack();
        s_fault();
        s_ptr();
        s_ctx();
        s_illegal();
        results();
    end
endmodule : csia_core_tb
